// >>> core/prs_phase_timer.sv
// Phase timer: counts cycles since the last clear and flags the last cycle.
// Assumes the caller clears it on every phase change.
`timescale 1ns/10ps

module prs_phase_timer #(
  parameter int CNT_W = 22
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expire_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // The count saturates at the limit so a phase that waits longer holds.
  always_comb begin
    cnt_d = cnt_q;
    if (clear_i) begin
      cnt_d = '0;
    end else if (cnt_q != limit_i) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // The last cycle of a phase is the one whose count equals the limit.
  assign count_o  = cnt_q;
  assign expire_o = (cnt_q == limit_i);

endmodule : prs_phase_timer

// >>> core/prs_pkg.sv
// Types shared by the startup sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package prs_pkg;

  // --------------------------------------------------------------------------
  // Startup phases, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ph_wait_rst = 5'b00001,
    ph_settle   = 5'b00010,
    ph_lock     = 5'b00100,
    ph_cal      = 5'b01000,
    ph_run      = 5'b10000
  } prs_phase_t;

endpackage : prs_pkg

// >>> core/prs_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// startup sequencer. Assumes a 200 MHz reference clock on the core clock.
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PRS_CLK_MHZ        200
`define PRS_SETTLE_MS      11
`define PRS_LOCK_US        50
`define PRS_CAL_MS_X100    205
`define PRS_SETTLE_CYC     (`PRS_SETTLE_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_LOCK_CYC       (`PRS_LOCK_US * `PRS_CLK_MHZ)
`define PRS_CAL_CYC        (`PRS_CAL_MS_X100 * 10 * `PRS_CLK_MHZ)

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define PRS_ADDR_CTRL      8'h00
`define PRS_ADDR_STATUS    8'h04
`define PRS_ADDR_STRAPS    8'h08

// Control fields and reset value.
`define PRS_CTRL_CLKOUT    0
`define PRS_CTRL_RESET     1'h1

// Status fields.
`define PRS_ST_PHASE_LSB   0
`define PRS_ST_PHASE_MSB   4
`define PRS_ST_MGMT_EN     5
`define PRS_ST_EELOAD      6
`define PRS_ST_CLKOUT      7

// Strap fields.
`define PRS_SP_PLL         0
`define PRS_SP_EEPROM      1
`define PRS_SP_CONFIG_MODE_STRAPS_LSB   2

`endif

// >>> core/prs_seq.sv
// Startup sequencer of a physical layer device, with a Wishbone slave.
// Assumes clk_i is the reference clock and pins arrive from outside it.
//
// What this block does
// - Start only on external reset rising edge.
// - Capture strap pins at reset release.
// - No EEPROM: management port on next edge.
// - With EEPROM: port off until script loaded.
// - Wait 11 ms settle after reset release.
// - Then wait 50 us for PLL lock.
// - Then calibrate the ADC for 2.05 ms.
// - Clock outputs only after calibration completes.
// - Management port usable before other blocks; with EEPROM it opens at load done, in whatever phase.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "prs_regs.svh"

module prs_seq #(
  parameter int CM_W       = 7,
  parameter int CNT_W      = 22,
  parameter int SETTLE_CYC = `PRS_SETTLE_CYC,
  parameter int LOCK_CYC   = `PRS_LOCK_CYC,
  parameter int CAL_CYC    = `PRS_CAL_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ext_reset_n_i,
  input  wire logic            pll_source_select_strap_i,
  input  wire logic            eeprom_data_strap_i,
  input  wire logic [CM_W-1:0] config_mode_straps_i,
  input  wire logic            eeprom_load_done_i,
  input  wire logic            mgmt_mdio_out_i,
  input  wire logic            mgmt_mdio_oe_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  output logic                 eeprom_load_req_o,
  output logic                 mgmt_enable_o,
  output logic                 mdio_o,
  output logic                 mdio_oe_o,
  output logic                 clkout_enable_o,
  output logic                 pll_source_select_o,
  output logic      [CM_W-1:0] config_mode_o
);

  localparam int SW = CM_W + 3;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Bit 0 is the reset pin, bit 1 the PLL strap, bit 2 the EEPROM strap.
  logic [SW-1:0] s1_q, s2_q, s3_q, acc_q, acc_d;
  logic          rise, fall;

  // A level is accepted only once the second and third stages agree.
  always_comb begin
    acc_d = (s2_q & s3_q) | (acc_q & (s2_q | s3_q));
    rise  = acc_d[0] & ~acc_q[0];
    fall  = acc_q[0] & ~acc_d[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      acc_q <= '0;
    end else begin
      s1_q  <= {config_mode_straps_i, eeprom_data_strap_i,
                pll_source_select_strap_i, ext_reset_n_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      acc_q <= acc_d;
    end
  end

  // --------------------------------------------------------------------------
  // Phase sequencing
  // --------------------------------------------------------------------------
  prs_pkg::prs_phase_t phase_q, phase_d;
  logic [CNT_W-1:0]    limit, count;
  logic                expire;
  logic                pll_q, pll_d, ee_q, ee_d;
  logic [CM_W-1:0]     cm_q, cm_d;
  logic                eeload_q, eeload_d, smi_q, smi_d;

  // Each wait is one counter run; a new reset assertion always wins.
  always_comb begin
    phase_d  = phase_q;
    pll_d    = pll_q;
    ee_d     = ee_q;
    cm_d     = cm_q;
    eeload_d = eeload_q;
    smi_d    = smi_q;
    case (phase_q)
      prs_pkg::ph_wait_rst: begin
        if (rise) begin
          phase_d = prs_pkg::ph_settle;
          pll_d   = acc_d[1];
          ee_d    = acc_d[2];
          cm_d    = acc_d[SW-1:3];
          if (acc_d[2]) begin
            eeload_d = 1'b1;
          end else begin
            smi_d = 1'b1;
          end
        end
      end
      prs_pkg::ph_settle: begin
        if (expire) begin
          phase_d = prs_pkg::ph_lock;
        end
      end
      prs_pkg::ph_lock: begin
        if (expire) begin
          phase_d = prs_pkg::ph_cal;
        end
      end
      prs_pkg::ph_cal: begin
        if (expire) begin
          phase_d = prs_pkg::ph_run;
        end
      end
      prs_pkg::ph_run: begin
        phase_d = prs_pkg::ph_run;
      end
      default: begin
        phase_d = prs_pkg::ph_wait_rst;
      end
    endcase
    // The port opens only once the loader reports the script applied.
    if (eeload_q && eeprom_load_done_i) begin
      eeload_d = 1'b0;
      smi_d    = 1'b1;
    end
    if (fall) begin
      phase_d  = prs_pkg::ph_wait_rst;
      eeload_d = 1'b0;
      smi_d    = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q  <= prs_pkg::ph_wait_rst;
      pll_q    <= 1'b0;
      ee_q     <= 1'b0;
      cm_q     <= '0;
      eeload_q <= 1'b0;
      smi_q    <= 1'b0;
    end else begin
      phase_q  <= phase_d;
      pll_q    <= pll_d;
      ee_q     <= ee_d;
      cm_q     <= cm_d;
      eeload_q <= eeload_d;
      smi_q    <= smi_d;
    end
  end

  // The limit is the last count of the phase, so each phase lasts exactly N.
  always_comb begin
    case (phase_q)
      prs_pkg::ph_settle: limit = CNT_W'(SETTLE_CYC - 1);
      prs_pkg::ph_lock:   limit = CNT_W'(LOCK_CYC - 1);
      prs_pkg::ph_cal:    limit = CNT_W'(CAL_CYC - 1);
      default:            limit = '0;
    endcase
  end

  prs_phase_timer #(
    .CNT_W    (CNT_W)
  ) u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (phase_d != phase_q),
    .limit_i  (limit),
    .count_o  (count),
    .expire_o (expire)
  );

  // --------------------------------------------------------------------------
  // Wishbone slave and outputs
  // --------------------------------------------------------------------------
  logic        ctrl_clk_q, ctrl_clk_d, ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic        clk_q, clk_d, mdio_q, mdio_d, oe_q, oe_d;

  // One wait state: ack follows the request by one cycle, then drops.
  // Unmapped reads return zero and unmapped writes are dropped.
  always_comb begin
    ack_d      = wb_cyc_i & wb_stb_i & ~ack_q;
    ctrl_clk_d = ctrl_clk_q;
    dat_d      = 32'h0000_0000;
    if (ack_d && wb_we_i && wb_adr_i == `PRS_ADDR_CTRL && wb_sel_i[0]) begin
      ctrl_clk_d = wb_dat_i[`PRS_CTRL_CLKOUT];
    end
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        `PRS_ADDR_CTRL: dat_d[`PRS_CTRL_CLKOUT] = ctrl_clk_q;
        `PRS_ADDR_STATUS: begin
          dat_d[`PRS_ST_PHASE_MSB:`PRS_ST_PHASE_LSB] = phase_q;
          dat_d[`PRS_ST_MGMT_EN] = smi_q;
          dat_d[`PRS_ST_EELOAD]  = eeload_q;
          dat_d[`PRS_ST_CLKOUT]  = clk_q;
        end
        `PRS_ADDR_STRAPS: begin
          dat_d[`PRS_SP_PLL]    = pll_q;
          dat_d[`PRS_SP_EEPROM] = ee_q;
          dat_d[`PRS_SP_CONFIG_MODE_STRAPS_LSB +: CM_W] = cm_q;
        end
        default: dat_d = 32'h0000_0000;
      endcase
    end
    // Clocks stay off until calibration ends; software may still gate them.
    clk_d  = (phase_d == prs_pkg::ph_run) & ctrl_clk_q;
    // A disabled port never drives the data line, whatever the engine asks.
    oe_d   = mgmt_mdio_oe_i & smi_d;
    mdio_d = mgmt_mdio_out_i & smi_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_clk_q <= `PRS_CTRL_RESET;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
      clk_q      <= 1'b0;
      oe_q       <= 1'b0;
      mdio_q     <= 1'b0;
    end else begin
      ctrl_clk_q <= ctrl_clk_d;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
      clk_q      <= clk_d;
      oe_q       <= oe_d;
      mdio_q     <= mdio_d;
    end
  end

  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = dat_q;
  assign eeprom_load_req_o   = eeload_q;
  assign mgmt_enable_o       = smi_q;
  assign mdio_o              = mdio_q;
  assign mdio_oe_o           = oe_q;
  assign clkout_enable_o     = clk_q;
  assign pll_source_select_o = pll_q;
  assign config_mode_o       = cm_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_start_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == prs_pkg::ph_wait_rst && phase_d != prs_pkg::ph_wait_rst) |-> rise)
    else $error("Sequence left idle without a reset rising edge.");

  a_strap_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    rise |=> (pll_q == $past(acc_d[1]) && ee_q == $past(acc_d[2])
              && cm_q == $past(acc_d[SW-1:3])))
    else $error("Straps not captured at reset release.");

  a_port_no_eeprom: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise && !acc_d[2]) |=> smi_q)
    else $error("Management port not enabled on the first edge.");

  a_port_eeprom_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    ((rise && acc_d[2]) || (eeload_q && !eeprom_load_done_i)) |=> !mgmt_enable_o)
    else $error("Management port opened before the script loaded.");

  a_settle_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == prs_pkg::ph_settle && phase_d == prs_pkg::ph_lock)
      |-> count == CNT_W'(SETTLE_CYC - 1))
    else $error("Settle phase length wrong.");

  a_lock_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == prs_pkg::ph_lock && phase_d == prs_pkg::ph_cal)
      |-> count == CNT_W'(LOCK_CYC - 1))
    else $error("Lock phase length wrong.");

  a_cal_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == prs_pkg::ph_cal && phase_d == prs_pkg::ph_run)
      |-> count == CNT_W'(CAL_CYC - 1))
    else $error("Calibration phase length wrong.");

  a_clock_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    clkout_enable_o |-> phase_q == prs_pkg::ph_run)
    else $error("Clock outputs active before calibration ended.");

  a_port_early: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_q == prs_pkg::ph_lock && !ee_q) |-> mgmt_enable_o)
    else $error("Management port not open ahead of other blocks.");

  a_restart_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    fall |=> (phase_q == prs_pkg::ph_wait_rst && !mgmt_enable_o) ##1 !clkout_enable_o)
    else $error("Sequence did not restart on reset assertion.");

  a_mdio_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !mgmt_enable_o |-> !mdio_oe_o)
    else $error("Data line driven while the port is disabled.");

endmodule : prs_seq

// >>> verification/prs_board_model.sv
// Board-side partner: reset pin source, EEPROM loader and management engine.
// Assumes the sequencer clock; the bench commands it by level.
`timescale 1ns/10ps

module prs_board_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic rude_i,
  input  wire logic load_req_i,
  input  wire logic mgmt_en_i,
  output logic      ext_reset_n_o,
  output logic      load_done_o,
  output logic      md_out_o,
  output logic      md_oe_o
);
  int wait_q;

  initial begin
    ext_reset_n_o = 1'b0;
    load_done_o   = 1'b0;
    md_out_o      = 1'b0;
    md_oe_o       = 1'b0;
    wait_q        = 0;
  end

  // The pin rises only on command, so supplies are taken as stable by then.
  // The engine talks in the early window; rude_i makes it talk too soon.
  always @(posedge clk_i) begin
    ext_reset_n_o <= go_i;
    md_out_o      <= 1'($urandom);
    md_oe_o       <= mgmt_en_i | rude_i;
    wait_q        <= load_req_i ? wait_q + 1 : 0;
    load_done_o   <= load_req_i && (wait_q == 30);
  end
endmodule : prs_board_model

// >>> verification/tb.sv
// Self-checking bench of the startup sequencer with short phase counts.
// Assumes the design files under core/ and the board model.
`timescale 1ns/10ps
`include "prs_regs.svh"

module tb;
  localparam int S = 40;
  localparam int L = 10;
  localparam int C = 20;
  logic clk_i = 0, rst_i = 1, go = 0, rude = 0, pll = 0, ee = 0;
  logic [6:0] cm = 0, cmo;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic ext_n, done, mdo, mdoe, ack, req, men, md, md_oe, clko, pllo, pmd;
  int fail_count = 0, checks_done = 0, tick = 0, n;
  logic [31:0] expq[$];

  always #2.5 clk_i = ~clk_i;

  prs_seq #(.SETTLE_CYC(S), .LOCK_CYC(L), .CAL_CYC(C)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_n),
    .pll_source_select_strap_i(pll), .eeprom_data_strap_i(ee),
    .config_mode_straps_i(cm), .eeprom_load_done_i(done),
    .mgmt_mdio_out_i(mdo), .mgmt_mdio_oe_i(mdoe), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .eeprom_load_req_o(req), .mgmt_enable_o(men), .mdio_o(md),
    .mdio_oe_o(md_oe), .clkout_enable_o(clko),
    .pll_source_select_o(pllo), .config_mode_o(cmo));

  prs_board_model i_board (
    .clk_i(clk_i), .go_i(go), .rude_i(rude), .load_req_i(req),
    .mgmt_en_i(men), .ext_reset_n_o(ext_n), .load_done_o(done),
    .md_out_o(mdo), .md_oe_o(mdoe));

  // --------------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------------
  // One place compares, so every mismatch is printed alike.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Classic cycle; the request is held until ack is sampled high.
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // A slave that never answers is a mismatch, not a silent skip.
    if (ack !== 1'b1) check("wb ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // The note is queued before the request, so the watcher never races it.
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // Waits for a sequencer level: 0 port enable, 1 clock enable, 2 load request.
  // A wait that runs out counts as a mismatch.
  task automatic until_high(int which);
    logic s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      s = (which == 0) ? men : ((which == 1) ? clko : req);
    end while (s !== 1'b1 && n < 500);
    if (s !== 1'b1) check("wait level", s, 1'b1);
  endtask : until_high

  // Read data is judged at the edge where ack is seen.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && cyc && !we) begin
      check("read data", rdat, expq.pop_front());
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // A hang is cut well beyond the few hundred cycles the run needs.
  always @(posedge clk_i) begin
    tick++;
    if (tick == 6000) begin
      fail_count++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(34));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    check("mgmt idle", men, 0);
    rd(`PRS_ADDR_CTRL, 32'h1);
    rd(`PRS_ADDR_STATUS, 32'h1);
    wb(1'b1, 8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    $display("test reset values done");
    {cm, pll} <= 8'($urandom);
    go <= 1'b1;
    until_high(0);
    until_high(1);
    check("run cycles", n, S + L + C);
    rd(`PRS_ADDR_STRAPS, {23'h0, cm, 1'b0, pll});
    rd(`PRS_ADDR_STATUS, 32'hb0);
    cm  <= ~cm;
    pll <= ~pll;
    rd(`PRS_ADDR_STRAPS, {23'h0, cm, 1'b0, pll});
    check("pll strap out", pllo, 1'(~pll));
    check("config_mode_straps out", cmo, 7'(~cm));
    repeat (4) begin
      @(posedge clk_i);
      pmd = mdo;
      @(posedge clk_i);
      check("mdio follow", md, pmd);
      check("mdio oe on", md_oe, 1'b1);
    end
    $display("test plain startup done");
    wb(1'b1, `PRS_ADDR_CTRL, 32'h0);
    go <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`PRS_ADDR_STATUS, 32'h1);
    ee   <= 1'b1;
    rude <= 1'b1;
    go   <= 1'b1;
    until_high(2);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (req === 1'b1) begin
        check("mdio oe off", md_oe, 0);
        check("mgmt off", men, 0);
      end
    end while (men !== 1'b1 && n < 200);
    check("load wait", n > 30, 1);
    check("mgmt on after load", men, 1'b1);
    repeat (S + L + C + 5) @(posedge clk_i);
    rd(`PRS_ADDR_STATUS, 32'h30);
    rd(`PRS_ADDR_STRAPS, {23'h0, cm, 1'b1, pll});
    check("clkout off", clko, 0);
    $display("test eeprom startup done");
    end_of_test();
  end
endmodule : tb
